/* File: inc/mcet_defines.svh */
// constants of the microcore execution trace unit
`ifndef MCET_DEFINES_SVH
`define MCET_DEFINES_SVH

`define MCET_ADDR_W          10
`define MCET_CORES           4
`define MCET_PRESCALER_TRACE 4'h3
`define MCET_CALIB_CYCLES    5'h10
`define MCET_GAP_TICKS       2'h2
`define MCET_POST_CYCLES     8'h10
`define MCET_CODE_BITS       3'h4

// path codes in normal code
`define MCET_CODE_DEFAULT    4'h5
`define MCET_CODE_FORK       4'hA
`define MCET_CODE_IRQ_DIAG   4'h4
`define MCET_CODE_IRQ_DRV    4'h2
`define MCET_CODE_IRQ_START  4'h3
`define MCET_CODE_WAIT2      4'h6
`define MCET_CODE_WAIT3      4'hB
`define MCET_CODE_WAIT4      4'hD
`define MCET_CODE_WAIT5      4'h9
// sync codes
`define MCET_CODE_START_SYNC 4'hA
`define MCET_CODE_STOP_SYNC  4'hC
// path codes after an automatic interrupt return
`define MCET_CODE_AUTO_FORK  4'h1
`define MCET_CODE_AUTO_DEF   4'h7
`define MCET_CODE_AUTO_W2    4'h4
`define MCET_CODE_AUTO_W3    4'h2
`define MCET_CODE_AUTO_W4    4'hE
`define MCET_CODE_AUTO_W5    4'h3

`endif

/* File: inc/mcet_pkg.sv */
// types of the microcore execution trace unit
package mcet_pkg;

    typedef enum logic [2:0] {
        PH_OFF,
        PH_CALIB,
        PH_GAP,
        PH_IDLE,
        PH_TRACE,
        PH_POST
    } mcet_phase_t;

    // path the current instruction takes; wait entry 1 counts as default
    typedef enum logic [2:0] {
        PATH_DEFAULT,
        PATH_FORKED,
        PATH_WAIT2,
        PATH_WAIT3,
        PATH_WAIT4,
        PATH_WAIT5
    } mcet_path_t;

    // kind of step reported by a microcore each microcode cycle
    typedef enum logic [3:0] {
        EV_PLAIN,
        EV_JUMP_UNCOND,
        EV_SUBR_JUMP,
        EV_SW_REQ,
        EV_IRQ_DIAG,
        EV_IRQ_DRV,
        EV_IRQ_START,
        EV_IRET_RESTART,
        EV_IRET_CONT,
        EV_AUTO_IRET
    } mcet_event_t;

    typedef struct packed {
        mcet_phase_t phase;
        logic [3:0]  divCnt;
        logic [4:0]  calCnt;
        logic [1:0]  gapCnt;
        logic [7:0]  postCnt;
        logic        inIsr;
        mcet_path_t  savedPath;
        logic [1:0]  lastCore;
        logic        pin;
    } mcet_top_state_t;

    typedef struct packed {
        logic [3:0] shreg;
        logic [2:0] left;
        logic       bitOut;
    } mcet_ser_state_t;

endpackage

/* File: inc/mcet_code_if.sv */
// code hand-off between trace sequencer and serialiser
`timescale 1ns/10ps

interface mcet_code_if;
    logic [3:0] code;
    logic       load;
    logic       busy;
    logic       serBit;

    modport src
    (
        output code,
        output load,
        input  busy,
        input  serBit
    );

    modport ser
    (
        input  code,
        input  load,
        output busy,
        output serBit
    );
endinterface

/* File: logic/mcet_shifter.sv */
// four-bit serialiser, most significant bit first
`timescale 1ns/10ps
`include "mcet_defines.svh"

module mcet_shifter
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    mcet_code_if.ser  cif
);

    mcet_pkg::mcet_ser_state_t s_q;
    mcet_pkg::mcet_ser_state_t s_d;

    // load a code, then shift one bit per system clock; line low when empty
    always_comb
    begin
        s_d = s_q;
        if (cif.load)
        begin
            s_d.bitOut = cif.code[3];
            s_d.shreg  = {cif.code[2:0], 1'b0};
            s_d.left   = `MCET_CODE_BITS - 3'h1;
        end
        else if (s_q.left != 3'h0)
        begin
            s_d.bitOut = s_q.shreg[3];
            s_d.shreg  = {s_q.shreg[2:0], 1'b0};
            s_d.left   = s_q.left - 3'h1;
        end
        else
        begin
            s_d.bitOut = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cif.busy   = (s_q.left != 3'h0);
    assign cif.serBit = s_q.bitOut;

    // code leaves msb first, one bit per clock
    msb_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cif.load |=> (cif.serBit == $past(cif.code[3])) ##1 (cif.serBit == $past(cif.code[2], 2))
        ##1 (cif.serBit == $past(cif.code[1], 3)) ##1 (cif.serBit == $past(cif.code[0], 4)))
        else $error("serial bits not msb first");

endmodule

/* File: logic/mcet_trace_unit.sv */
// execution trace unit: calibration, sync, path codes, stop and tail
`timescale 1ns/10ps
`include "mcet_defines.svh"

module mcet_trace_unit
#(
    parameter logic [7:0] POST_CYCLES = `MCET_POST_CYCLES
)
(
    input  wire logic                                      clk_sys,
    input  wire logic                                      sys_rst,
    input  wire logic                                      traceEnable,
    input  wire logic [1:0]                                coreSelect,
    input  wire logic [`MCET_ADDR_W-1:0]                   syncAddress,
    input  wire logic [`MCET_ADDR_W-1:0]                   stopAddress,
    input  wire logic [3:0]                                clockPrescaler,
    input  wire logic [`MCET_CORES-1:0][`MCET_ADDR_W-1:0]  microprogramCounter,
    input  wire mcet_pkg::mcet_event_t [`MCET_CORES-1:0]   coreEvent,
    input  wire mcet_pkg::mcet_path_t  [`MCET_CORES-1:0]   corePath,
    output logic                                           traceSerialPin,
    output mcet_pkg::mcet_phase_t                          tracePhase,
    output logic                                           microcodeExecTick
);

    mcet_pkg::mcet_top_state_t s_q;
    mcet_pkg::mcet_top_state_t s_d;
    mcet_code_if               cif ();

    logic                   runOk;
    logic                   ckTick;
    logic [`MCET_ADDR_W-1:0] selPc;
    mcet_pkg::mcet_event_t  selEvent;
    mcet_pkg::mcet_path_t   selPath;
    logic [3:0]             pathCode;
    logic [3:0]             codeD;
    logic                   loadD;

    // normal-code code of a path
    function automatic logic [3:0] mcet_normal_code(input mcet_pkg::mcet_path_t p);
        logic [3:0] c;
        c = `MCET_CODE_DEFAULT;
        case (p)
            mcet_pkg::PATH_FORKED: c = `MCET_CODE_FORK;
            mcet_pkg::PATH_WAIT2:  c = `MCET_CODE_WAIT2;
            mcet_pkg::PATH_WAIT3:  c = `MCET_CODE_WAIT3;
            mcet_pkg::PATH_WAIT4:  c = `MCET_CODE_WAIT4;
            mcet_pkg::PATH_WAIT5:  c = `MCET_CODE_WAIT5;
            default:               c = `MCET_CODE_DEFAULT;
        endcase
        return c;
    endfunction

    // code of a path resumed by an automatic interrupt return
    function automatic logic [3:0] mcet_auto_code(input mcet_pkg::mcet_path_t p);
        logic [3:0] c;
        c = `MCET_CODE_AUTO_DEF;
        case (p)
            mcet_pkg::PATH_FORKED: c = `MCET_CODE_AUTO_FORK;
            mcet_pkg::PATH_WAIT2:  c = `MCET_CODE_AUTO_W2;
            mcet_pkg::PATH_WAIT3:  c = `MCET_CODE_AUTO_W3;
            mcet_pkg::PATH_WAIT4:  c = `MCET_CODE_AUTO_W4;
            mcet_pkg::PATH_WAIT5:  c = `MCET_CODE_AUTO_W5;
            default:               c = `MCET_CODE_AUTO_DEF;
        endcase
        return c;
    endfunction

    // selected core only
    assign selPc    = microprogramCounter[coreSelect];
    assign selEvent = coreEvent[coreSelect];
    assign selPath  = corePath[coreSelect];

    assign runOk  = traceEnable && (clockPrescaler == `MCET_PRESCALER_TRACE);
    assign ckTick = (s_q.divCnt == clockPrescaler);

    // path code of the current step, context aware
    always_comb
    begin
        pathCode = mcet_normal_code(selPath);
        case (selEvent)
            mcet_pkg::EV_JUMP_UNCOND:  pathCode = `MCET_CODE_FORK;
            mcet_pkg::EV_SUBR_JUMP:    pathCode = `MCET_CODE_FORK;
            mcet_pkg::EV_SW_REQ:       pathCode = `MCET_CODE_FORK;
            mcet_pkg::EV_IRQ_DIAG:     pathCode = `MCET_CODE_IRQ_DIAG;
            mcet_pkg::EV_IRQ_DRV:      pathCode = `MCET_CODE_IRQ_DRV;
            mcet_pkg::EV_IRQ_START:    pathCode = `MCET_CODE_IRQ_START;
            mcet_pkg::EV_IRET_RESTART: pathCode = `MCET_CODE_FORK;
            mcet_pkg::EV_IRET_CONT:
            begin
                if (s_q.inIsr)
                    pathCode = mcet_normal_code(s_q.savedPath);
            end
            mcet_pkg::EV_AUTO_IRET:
            begin
                if (s_q.inIsr)
                    pathCode = mcet_auto_code(s_q.savedPath);
            end
            default: ;
        endcase
    end

    // sequencer, divider, context tracking and pin
    always_comb
    begin
        s_d   = s_q;
        loadD = 1'b0;
        codeD = `MCET_CODE_DEFAULT;

        // microcode clock enable from the prescaler
        s_d.divCnt = ckTick ? 4'h0 : s_q.divCnt + 4'h1;

        // interrupt context of the selected core
        if (coreSelect != s_q.lastCore)
        begin
            s_d.inIsr    = 1'b0;
            s_d.lastCore = coreSelect;
        end
        else if (ckTick)
        begin
            case (selEvent)
                mcet_pkg::EV_IRQ_DIAG, mcet_pkg::EV_IRQ_DRV, mcet_pkg::EV_IRQ_START:
                begin
                    s_d.inIsr     = 1'b1;
                    s_d.savedPath = selPath;
                end
                mcet_pkg::EV_IRET_RESTART, mcet_pkg::EV_IRET_CONT, mcet_pkg::EV_AUTO_IRET:
                    s_d.inIsr = 1'b0;
                default: ;
            endcase
        end

        case (s_q.phase)
            mcet_pkg::PH_OFF:
            begin
                s_d.calCnt = 5'h0;
                if (runOk)
                    s_d.phase = mcet_pkg::PH_CALIB;
            end
            mcet_pkg::PH_CALIB:
            begin
                s_d.calCnt = s_q.calCnt + 5'h1;
                if (s_q.calCnt == `MCET_CALIB_CYCLES - 5'h1)
                begin
                    s_d.phase  = mcet_pkg::PH_GAP;
                    s_d.gapCnt = 2'h0;
                end
            end
            mcet_pkg::PH_GAP:
            begin
                // two ticks guarantee one whole microcode period low
                if (ckTick)
                    s_d.gapCnt = s_q.gapCnt + 2'h1;
                if (ckTick && (s_q.gapCnt == `MCET_GAP_TICKS - 2'h1))
                    s_d.phase = mcet_pkg::PH_IDLE;
            end
            mcet_pkg::PH_IDLE:
            begin
                if (ckTick && (selPc == syncAddress))
                begin
                    loadD     = 1'b1;
                    codeD     = `MCET_CODE_START_SYNC;
                    s_d.phase = mcet_pkg::PH_TRACE;
                end
            end
            mcet_pkg::PH_TRACE:
            begin
                if (ckTick)
                begin
                    loadD = 1'b1;
                    if (selPc == stopAddress)
                    begin
                        codeD       = `MCET_CODE_STOP_SYNC;
                        s_d.phase   = mcet_pkg::PH_POST;
                        s_d.postCnt = 8'h0;
                    end
                    else
                        codeD = pathCode;
                end
            end
            mcet_pkg::PH_POST:
            begin
                if (ckTick)
                begin
                    loadD       = 1'b1;
                    codeD       = pathCode;
                    s_d.postCnt = s_q.postCnt + 8'h1;
                    if (s_q.postCnt == POST_CYCLES - 8'h1)
                        s_d.phase = mcet_pkg::PH_IDLE;
                end
            end
            default:
                s_d.phase = mcet_pkg::PH_OFF;
        endcase

        if (!runOk)
            s_d.phase = mcet_pkg::PH_OFF;

        // calibration square wave, otherwise serial bits, else static low
        case (s_q.phase)
            mcet_pkg::PH_CALIB: s_d.pin = ~s_q.calCnt[0];
            mcet_pkg::PH_IDLE, mcet_pkg::PH_TRACE, mcet_pkg::PH_POST:
                s_d.pin = cif.serBit;
            default: s_d.pin = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_q       <= '0;
            s_q.phase <= mcet_pkg::PH_OFF;
        end
        else
            s_q <= s_d;
    end

    assign cif.load = loadD;
    assign cif.code = codeD;

    mcet_shifter mcet_shifter_inst
    (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .cif     (cif)
    );

    assign traceSerialPin    = s_q.pin;
    assign tracePhase        = s_q.phase;
    assign microcodeExecTick = ckTick;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // wrong prescaler forbids tracing
    prescale_gate_a: assert property (
        (clockPrescaler != `MCET_PRESCALER_TRACE) |=> (tracePhase == mcet_pkg::PH_OFF))
        else $error("trace active with wrong prescaler");

    // sixteen calibration cycles then the gap
    calib_length_a: assert property (
        (tracePhase == mcet_pkg::PH_OFF && runOk) |=> (tracePhase == mcet_pkg::PH_CALIB)[*8]
        ##1 (tracePhase == mcet_pkg::PH_CALIB)[*8] ##1 (tracePhase == mcet_pkg::PH_GAP || !runOk))
        else $error("calibration burst length wrong");

    // calibration toggles at half the clock
    calib_wave_a: assert property (
        (tracePhase == mcet_pkg::PH_CALIB) |=> (traceSerialPin == ~$past(s_q.calCnt[0])))
        else $error("calibration wave wrong");

    // pin low during the gap
    gap_low_a: assert property (
        (tracePhase == mcet_pkg::PH_GAP) |=> (traceSerialPin == 1'b0))
        else $error("pin not low after calibration");

    // start sync on sync address
    start_sync_a: assert property (
        (tracePhase == mcet_pkg::PH_IDLE && ckTick && runOk && selPc == syncAddress)
        |-> (cif.load && cif.code == 4'hA) ##1 (tracePhase == mcet_pkg::PH_TRACE))
        else $error("start sync missing");

    // forbidden codes never loaded
    no_flat_code_a: assert property (
        cif.load |-> (cif.code != 4'h0 && cif.code != 4'hF))
        else $error("flat code loaded");

    // unconditional jump never default
    jump_not_default_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && selPc != stopAddress
         && selEvent == mcet_pkg::EV_JUMP_UNCOND) |-> (cif.load && cif.code == 4'hA))
        else $error("jump sent default code");

    // software request always forked
    sw_req_fork_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && selPc != stopAddress
         && selEvent == mcet_pkg::EV_SW_REQ) |-> (cif.code == 4'hA))
        else $error("request not forked");

    // interrupt entries carry their own codes
    irq_codes_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && selPc != stopAddress)
        |-> ((selEvent != mcet_pkg::EV_IRQ_DIAG || cif.code == 4'h4)
          && (selEvent != mcet_pkg::EV_IRQ_DRV || cif.code == 4'h2)
          && (selEvent != mcet_pkg::EV_IRQ_START || cif.code == 4'h3)))
        else $error("interrupt entry code wrong");

    // driver interrupt entry enters routine context
    isr_enter_a: assert property (
        (ckTick && coreSelect == s_q.lastCore && selEvent == mcet_pkg::EV_IRQ_DRV)
        |=> s_q.inIsr)
        else $error("routine context not tracked");

    // wait entries in normal code
    wait_codes_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && selPc != stopAddress
         && selEvent == mcet_pkg::EV_PLAIN)
        |-> ((selPath != mcet_pkg::PATH_WAIT2 || cif.code == 4'h6)
          && (selPath != mcet_pkg::PATH_WAIT3 || cif.code == 4'hB)
          && (selPath != mcet_pkg::PATH_WAIT4 || cif.code == 4'hD)
          && (selPath != mcet_pkg::PATH_WAIT5 || cif.code == 4'h9)))
        else $error("wait entry code wrong");

    // restart return is forked
    iret_restart_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && selPc != stopAddress
         && selEvent == mcet_pkg::EV_IRET_RESTART) |-> (cif.code == 4'hA))
        else $error("restart return code wrong");

    // stop sync then tail
    stop_sync_a: assert property (
        (tracePhase == mcet_pkg::PH_TRACE && ckTick && runOk && selPc == stopAddress)
        |-> (cif.code == 4'hC) ##1 (tracePhase == mcet_pkg::PH_POST))
        else $error("stop sync missing");

    // tail ends after its count
    post_end_a: assert property (
        (tracePhase == mcet_pkg::PH_POST && ckTick && runOk && s_q.postCnt == POST_CYCLES - 8'h1)
        |=> (tracePhase == mcet_pkg::PH_IDLE))
        else $error("tail length wrong");

    // pin static while off
    off_static_a: assert property (
        (tracePhase == mcet_pkg::PH_OFF) |=> (traceSerialPin == 1'b0))
        else $error("pin moves while off");

endmodule

/* File: tb/mcet_tracer_model.sv */
// tracer model: counts eight calibration pulses, then decodes four-bit codes off the debug pin, one bit per clock
`timescale 1ns/10ps

module mcet_tracer_model
(
    input wire logic clk_sys,
    input wire logic rearm,
    input wire logic traceSerialPin
);
    logic [3:0] calPulses = 4'h0;
    logic       prevPin   = 1'b0;
    logic       inFrame   = 1'b0;
    logic [1:0] bitCnt    = 2'h0;
    logic [3:0] shiftIn   = 4'h0;
    logic [3:0] codes[$];

    // calibration pulses first, then frames opened by the first high bit
    always @(posedge clk_sys)
    begin
        if (rearm)
        begin
            calPulses = 4'h0;
            inFrame = 1'b0;
            bitCnt = 2'h0;
            codes.delete();
        end
        else if (calPulses != 4'h8)
        begin
            if (traceSerialPin && !prevPin)
                calPulses = calPulses + 4'h1;
        end
        else if (inFrame || traceSerialPin)
        begin
            shiftIn = {shiftIn[2:0], traceSerialPin};
            inFrame = 1'b1;
            if (bitCnt == 2'h3)
            begin
                if (shiftIn == 4'h0)
                    inFrame = 1'b0;
                else
                    codes.push_back(shiftIn);
            end
            bitCnt = bitCnt + 2'h1;
        end
        prevPin = traceSerialPin;
    end
endmodule

/* File: tb/microcore_execution_trace_tb.sv */
// self-checking bench for the microcore execution trace unit
`timescale 1ns/10ps
`include "mcet_defines.svh"

module microcore_execution_trace_tb;
    logic                                     clk_sys;
    logic                                     sys_rst;
    logic                                     traceEnable;
    logic [1:0]                               coreSelect;
    logic [`MCET_ADDR_W-1:0]                  syncAddress;
    logic [`MCET_ADDR_W-1:0]                  stopAddress;
    logic [3:0]                               clockPrescaler;
    logic [`MCET_CORES-1:0][`MCET_ADDR_W-1:0] microprogramCounter;
    mcet_pkg::mcet_event_t [`MCET_CORES-1:0]  coreEvent;
    mcet_pkg::mcet_path_t  [`MCET_CORES-1:0]  corePath;
    logic                                     traceSerialPin;
    mcet_pkg::mcet_phase_t                    tracePhase;
    logic                                     microcodeExecTick;
    logic                                     rearm;
    logic [`MCET_ADDR_W-1:0]                  pcNow;
    logic [3:0]                               expCodes[$];
    int                                       n_errors = 0;
    int                                       checks = 0;

    mcet_trace_unit #(.POST_CYCLES(8'h02)) mcet_trace_unit_inst
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .traceEnable(traceEnable),
        .coreSelect(coreSelect), .syncAddress(syncAddress), .stopAddress(stopAddress),
        .clockPrescaler(clockPrescaler), .microprogramCounter(microprogramCounter),
        .coreEvent(coreEvent), .corePath(corePath), .traceSerialPin(traceSerialPin),
        .tracePhase(tracePhase), .microcodeExecTick(microcodeExecTick)
    );

    mcet_tracer_model mcet_tracer_model_inst
    (
        .clk_sys(clk_sys), .rearm(rearm), .traceSerialPin(traceSerialPin)
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    task chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        begin
            checks++;
            if (got !== expv)
            begin
                n_errors++;
                $display("CHECK FAILED %s expected %0h seen %0h", what, expv, got);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // presents one microcode step of core 2 at the next tick
    task step(input mcet_pkg::mcet_event_t ev, input mcet_pkg::mcet_path_t pth,
              input logic [3:0] expv);
        int n;
        begin
            n = 0;
            while (microcodeExecTick !== 1'b1 && n < 20)
            begin
                @(negedge clk_sys);
                n++;
            end
            microprogramCounter[2] = pcNow;
            coreEvent[2] = ev;
            corePath[2] = pth;
            pcNow = pcNow + 10'h001;
            if (expv !== 4'h0)
                expCodes.push_back(expv);
            @(negedge clk_sys);
        end
    endtask

    task test_refuse;
        logic bad;
        begin
            for (int p = 0; p < 6; p++)
            begin
                bad = 1'b0;
                clockPrescaler = p[3:0];
                traceEnable = (p != 3);
                repeat (20)
                begin
                    @(negedge clk_sys);
                    bad |= (tracePhase !== mcet_pkg::PH_OFF) || (traceSerialPin !== 1'b0);
                end
                chk("refused prescaler stays off", 0, bad);
            end
            $display("test refuse done");
        end
    endtask

    task test_calib;
        int   rises;
        int   highs;
        int   lastHigh;
        int   cyc;
        logic prev;
        begin
            rises = 0;
            highs = 0;
            lastHigh = 0;
            prev = 1'b0;
            rearm = 1'b1;
            @(negedge clk_sys);
            rearm = 1'b0;
            clockPrescaler = 4'h3;
            traceEnable = 1'b1;
            for (cyc = 0; cyc < 80 && tracePhase !== mcet_pkg::PH_IDLE; cyc++)
            begin
                @(negedge clk_sys);
                if (traceSerialPin === 1'b1)
                begin
                    highs++;
                    lastHigh = cyc;
                    if (!prev)
                        rises++;
                end
                prev = traceSerialPin;
            end
            chk("calibration rises", 8, rises);
            chk("calibration high cycles", 8, highs);
            chk("tracer calibration count", 8, mcet_tracer_model_inst.calPulses);
            chk("low gap covers one period", 1, (cyc - lastHigh) >= 4);
            chk("phase idle after gap", mcet_pkg::PH_IDLE, tracePhase);
            // one microcode period is prescaler plus one system cycles
            cyc = 0;
            while (microcodeExecTick !== 1'b1 && cyc < 8)
            begin
                @(negedge clk_sys);
                cyc++;
            end
            cyc = 1;
            @(negedge clk_sys);
            while (microcodeExecTick !== 1'b1 && cyc < 8)
            begin
                @(negedge clk_sys);
                cyc++;
            end
            chk("microcode period", 4, cyc);
            $display("test calibration done");
        end
    endtask

    task test_trace;
        begin
            expCodes.delete();
            pcNow = 10'h100;
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'h0);
            pcNow = syncAddress;
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'hA);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'h5);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_FORKED, 4'hA);
            step(mcet_pkg::EV_JUMP_UNCOND, mcet_pkg::PATH_DEFAULT, 4'hA);
            step(mcet_pkg::EV_SUBR_JUMP, mcet_pkg::PATH_DEFAULT, 4'hA);
            step(mcet_pkg::EV_SW_REQ, mcet_pkg::PATH_DEFAULT, 4'hA);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT2, 4'h6);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT3, 4'hB);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT4, 4'hD);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT5, 4'h9);
            step(mcet_pkg::EV_IRQ_DIAG, mcet_pkg::PATH_WAIT3, 4'h4);
            step(mcet_pkg::EV_IRET_CONT, mcet_pkg::PATH_DEFAULT, 4'hB);
            step(mcet_pkg::EV_IRQ_DRV, mcet_pkg::PATH_DEFAULT, 4'h2);
            step(mcet_pkg::EV_AUTO_IRET, mcet_pkg::PATH_FORKED, 4'h7);
            step(mcet_pkg::EV_IRQ_START, mcet_pkg::PATH_FORKED, 4'h3);
            step(mcet_pkg::EV_IRET_RESTART, mcet_pkg::PATH_WAIT2, 4'hA);
            step(mcet_pkg::EV_AUTO_IRET, mcet_pkg::PATH_WAIT4, 4'hD);
            pcNow = stopAddress;
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT4, 4'hC);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'h5);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'h5);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'h0);
            repeat (30) @(negedge clk_sys);
            chk("phase idle after tail", mcet_pkg::PH_IDLE, tracePhase);
            chk("code count", expCodes.size(), mcet_tracer_model_inst.codes.size());
            foreach (expCodes[i])
                chk($sformatf("code %0d", i), expCodes[i], mcet_tracer_model_inst.codes[i]);
            $display("test trace done");
        end
    endtask

    task test_abort;
        logic bad;
        begin
            bad = 1'b0;
            traceEnable = 1'b0;
            @(negedge clk_sys);
            test_calib();
            pcNow = syncAddress;
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_DEFAULT, 4'hA);
            step(mcet_pkg::EV_PLAIN, mcet_pkg::PATH_WAIT5, 4'h9);
            traceEnable = 1'b0;
            @(negedge clk_sys);
            chk("phase off after disable", mcet_pkg::PH_OFF, tracePhase);
            repeat (10)
            begin
                @(negedge clk_sys);
                bad |= (traceSerialPin !== 1'b0);
            end
            chk("pin low after disable", 0, bad);
            test_calib();
            // reset in mid-run drops the unit back to off
            sys_rst = 1'b1;
            repeat (2) @(negedge clk_sys);
            chk("phase off after mid reset", mcet_pkg::PH_OFF, tracePhase);
            chk("pin low after mid reset", 0, traceSerialPin);
            sys_rst = 1'b0;
            $display("test abort done");
        end
    endtask

    // watchdog against a hung handshake
    initial
    begin
        #(5 * 20000);
        n_errors++;
        $display("CHECK FAILED watchdog expected end seen hang");
        final_report();
    end

    initial
    begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        rearm = 1'b1;
        traceEnable = 1'b0;
        coreSelect = 2'h2;
        syncAddress = 10'h155;
        stopAddress = 10'h2AA;
        clockPrescaler = 4'h3;
        pcNow = 10'h100;
        microprogramCounter[0] = 10'h155;
        microprogramCounter[1] = 10'h2AA;
        microprogramCounter[2] = 10'h100;
        microprogramCounter[3] = 10'h2AA;
        for (int i = 0; i < 4; i++)
        begin
            coreEvent[i] = mcet_pkg::EV_SW_REQ;
            corePath[i] = mcet_pkg::PATH_WAIT5;
        end
        coreEvent[2] = mcet_pkg::EV_PLAIN;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("phase off after reset", mcet_pkg::PH_OFF, tracePhase);
        chk("pin low after reset", 0, traceSerialPin);
        $display("test reset done");
        test_refuse();
        test_calib();
        test_trace();
        test_abort();
        final_report();
    end
endmodule
